// [logic/pcs_pkg.sv]
// Package: register map, fields, constants and carriers of the PLL counter sync and lock detector
// Functional notes
// R1: Enabled sync pin event resets reference and both feedback counters together.
// R2: Two-bit sync enable field in delay/sync register; disabled after reset.
// R3: Reference and feedback paths each have an enableable delay, three-bit code.
// R4: Lock flag selectable on lock, status and reference monitor pins, per-pin mux.
// R5: Lock after programmed count of consecutive cycles inside lock window.
// R6: Once locked, one cycle beyond unlock window drops lock.
// R7: Unlock window is wider than the lock window.
// R8: Window widths follow window select bit and anti-backlash setting.
// R9: Phase detector period must exceed the unlock window.
// R10: Very low loop bandwidth should use the capacitor lock mode.
// R11: B count of one bypasses both counters; divide equals prescaler.
// R12: Fixed divide mode bypasses the A counter.
// R13: Dual modulus two-over-three not above 200 MHz; else prescaler of one.
// R14: Feedback divide is P times B plus A, P from 1 to 32.
// R15: After reset the detector reports unlocked with its counter cleared.
`default_nettype none
package pcs_pkg;
    localparam int unsigned CLK_MHZ = 50;
    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PRESCALER = 8'h16;
    localparam logic [7:0] IDX_ANTIBACKLASH = 8'h17;
    localparam logic [7:0] IDX_LOCK_CFG = 8'h18;
    localparam logic [7:0] IDX_DELAY_SYNC = 8'h19;
    localparam logic [7:0] IDX_LOCK_PIN_SEL = 8'h1a;
    localparam logic [7:0] IDX_REFERENCE_MONITOR_PIN_SEL = 8'h1b;
    localparam logic [7:0] IDX_A_COUNT = 8'h30;
    localparam logic [7:0] IDX_B_COUNT = 8'h31;
    localparam logic [7:0] IDX_DELAY_EN = 8'h32;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h38;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h39;
    localparam logic [7:0] IDX_LOCK_STATE = 8'h3a;
    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned PSC_SEL_LSB = 0;
    localparam int unsigned FD_BIT = 3;
    localparam int unsigned ABL_LSB = 0;
    localparam int unsigned STATUS_SEL_LSB = 2;
    localparam int unsigned LWIN_BIT = 4;
    localparam int unsigned LCNT_LSB = 5;
    localparam int unsigned REF_DLY_LSB = 0;
    localparam int unsigned FB_DLY_LSB = 3;
    localparam int unsigned SYNC_EN_LSB = 6;
    localparam int unsigned IRQ_LOCKED = 0;
    localparam int unsigned IRQ_UNLOCKED = 1;
    localparam int unsigned IRQ_SYNC = 2;
    localparam int unsigned IRQ_MISSED = 3;
    localparam logic [7:0] CFG_RESET = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // Lock window timing
    localparam int unsigned LD_LOCK_NS = 100;
    localparam logic [7:0] LD_LOCK_CYC = 8'((LD_LOCK_NS * CLK_MHZ) / 1000);
    localparam logic [7:0] ABL_MULT [0:3] = '{8'h02, 8'h01, 8'h03, 8'h04};
    localparam logic [7:0] LD_COUNTS [0:3] = '{8'h05, 8'h10, 8'h40, 8'hff};
    localparam logic [5:0] PSC_VALUES [0:7] =
        '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h01, 6'h01, 6'h01};
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_REF_FIRST = 3'b010,
        PH_FB_FIRST = 3'b100
    } pcs_phase_type;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pcs_apb_req_type;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pcs_apb_rsp_type;
    typedef struct packed {
        logic ref_en;
        logic [2:0] ref_code;
        logic fb_en;
        logic [2:0] fb_code;
    } pcs_delay_type;
    typedef struct packed {
        logic lock_pin;
        logic status_pin;
        logic reference_monitor_pin;
    } pcs_pins_type;
endpackage
`default_nettype wire

// [logic/pcs_top.sv]
// Module: counter sync pulse, divider delays, feedback divide and digital lock detector
`default_nettype none
module pcs_top (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire pcs_pkg::pcs_apb_req_type APB_REQ,
    output var pcs_pkg::pcs_apb_rsp_type APB_RSP,
    input wire logic REF_PFD_IN,
    input wire logic FB_PFD_IN,
    input wire logic SYNC_N,
    output logic COUNTER_RESET,
    output var pcs_pkg::pcs_delay_type DELAY_CFG,
    output logic [18:0] FB_DIVIDE,
    output logic FB_A_BYPASS,
    output logic FB_B_BYPASS,
    output var pcs_pkg::pcs_pins_type PINS,
    output logic IRQ
);
    import pcs_pkg::*;

    typedef struct packed {
        logic [7:0] prescaler;
        logic [7:0] abl;
        logic [7:0] lock_cfg;
        logic [7:0] delay_sync;
        logic [7:0] lock_sel;
        logic [7:0] reference_monitor_pin_sel;
        logic [5:0] a_count;
        logic [12:0] b_count;
        logic [1:0] delay_en;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic [31:0] prdata;
        logic [2:0][2:0] sync;
        logic [2:0] level;
        pcs_phase_type phase;
        logic [7:0] spacing;
        logic [7:0] good_count;
        logic locked;
        logic counter_reset;
        logic [18:0] fb_divide;
        logic a_bypass;
        logic b_bypass;
        pcs_pins_type pins;
    } pcs_state_type;

    localparam pcs_state_type ST_RESET = '{phase: PH_IDLE, default: '0};

    pcs_state_type st_ff;
    pcs_state_type nxt_st;
    logic [2:0] pin_in;
    logic ref_rise;
    logic fb_rise;
    logic sync_fall;
    logic sync_en;
    logic done;
    logic missed;
    logic [7:0] meas;
    logic [7:0] base_thr;
    logic [7:0] lock_thr;
    logic [7:0] unlock_thr;
    logic [7:0] need;
    logic good;
    logic bad;
    logic [3:0] events;
    logic [3:0] w1c;
    logic setup;
    logic access;
    logic hit;
    logic [7:0] idx;
    logic [31:0] rd_val;
    logic [5:0] psc;
    logic [18:0] prod;

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction

    function automatic logic pin_mux(input logic [1:0] sel, input logic flag);
        logic r;
        r = 1'b0;
        unique case (sel)
            2'b00: r = 1'b0;
            2'b01: r = flag;
            2'b10: r = ~flag;
            2'b11: r = 1'b1;
        endcase
        return r;
    endfunction

    assign pin_in = {SYNC_N, FB_PFD_IN, REF_PFD_IN};
    assign setup = APB_REQ.psel & ~APB_REQ.penable;
    assign access = APB_REQ.psel & APB_REQ.penable;
    assign idx = APB_REQ.paddr[9:2];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and read mux
    always_comb begin
        hit = (APB_REQ.paddr[11:10] == 2'b00);
        rd_val = 32'h0000_0000;
        unique case (idx)
            IDX_PRESCALER: rd_val = {24'h00_0000, st_ff.prescaler};
            IDX_ANTIBACKLASH: rd_val = {24'h00_0000, st_ff.abl};
            IDX_LOCK_CFG: rd_val = {24'h00_0000, st_ff.lock_cfg};
            IDX_DELAY_SYNC: rd_val = {24'h00_0000, st_ff.delay_sync};
            IDX_LOCK_PIN_SEL: rd_val = {24'h00_0000, st_ff.lock_sel};
            IDX_REFERENCE_MONITOR_PIN_SEL: rd_val = {24'h00_0000, st_ff.reference_monitor_pin_sel};
            IDX_A_COUNT: rd_val = {26'h0, st_ff.a_count};
            IDX_B_COUNT: rd_val = {19'h0, st_ff.b_count};
            IDX_DELAY_EN: rd_val = {30'h0, st_ff.delay_en};
            IDX_IRQ_STATUS: rd_val = {28'h000_0000, st_ff.irq_status};
            IDX_IRQ_MASK: rd_val = {28'h000_0000, st_ff.irq_mask};
            IDX_LOCK_STATE: rd_val = {16'h0000, st_ff.good_count, 7'h00, st_ff.locked};
            default: hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Window thresholds and feedback divide terms
    always_comb begin
        base_thr = LD_LOCK_CYC * ABL_MULT[st_ff.abl[ABL_LSB +: 2]]; // R8
        lock_thr = st_ff.lock_cfg[LWIN_BIT] ? {base_thr[6:0], 1'b0} : base_thr; // R8
        unlock_thr = {lock_thr[6:0], 1'b0}; // R7
        need = LD_COUNTS[st_ff.lock_cfg[LCNT_LSB +: 2]]; // R5
        psc = PSC_VALUES[st_ff.prescaler[PSC_SEL_LSB +: 3]]; // R14
        prod = 19'(psc) * 19'(st_ff.b_count); // R14
        sync_en = (st_ff.delay_sync[SYNC_EN_LSB +: 2] != 2'b00); // R2
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_st = st_ff;
        w1c = 4'h0;
        // Pin inputs: three stages, level moves once stages two and three agree
        for (int i = 0; i < 3; i++) begin
            nxt_st.sync[i] = {st_ff.sync[i][1:0], pin_in[i]};
            if (st_ff.sync[i][1] == st_ff.sync[i][2]) begin
                nxt_st.level[i] = st_ff.sync[i][2];
            end
        end
        ref_rise = nxt_st.level[0] & ~st_ff.level[0];
        fb_rise = nxt_st.level[1] & ~st_ff.level[1];
        sync_fall = st_ff.level[2] & ~nxt_st.level[2];
        // Sync pin pulse hits R, A and B counters in the same cycle
        nxt_st.counter_reset = sync_fall & sync_en; // R1
        // Edge spacing measurement, one result per phase detector cycle
        done = 1'b0;
        missed = 1'b0;
        meas = 8'h00;
        unique case (st_ff.phase)
            PH_IDLE: begin
                if (ref_rise && fb_rise) begin
                    done = 1'b1;
                end else if (ref_rise) begin
                    nxt_st.phase = PH_REF_FIRST;
                    nxt_st.spacing = 8'h00;
                end else if (fb_rise) begin
                    nxt_st.phase = PH_FB_FIRST;
                    nxt_st.spacing = 8'h00;
                end
            end
            PH_REF_FIRST, PH_FB_FIRST: begin
                nxt_st.spacing = sat_inc(st_ff.spacing);
                // A repeated edge means the period is too short; a saturated count means the other edge is missing or too late
                if ((st_ff.phase == PH_REF_FIRST) ? ref_rise : fb_rise) begin // R9
                    done = 1'b1;
                    missed = 1'b1;
                    meas = 8'hff;
                    nxt_st.spacing = 8'h00;
                end else if ((st_ff.phase == PH_REF_FIRST) ? fb_rise : ref_rise) begin
                    done = 1'b1;
                    meas = sat_inc(st_ff.spacing);
                    nxt_st.phase = PH_IDLE;
                end else if (st_ff.spacing == 8'hff) begin // R9
                    done = 1'b1;
                    missed = 1'b1;
                    meas = 8'hff;
                    nxt_st.phase = PH_IDLE;
                end
            end
            default: nxt_st.phase = PH_IDLE;
        endcase
        good = done && (meas < lock_thr); // R5
        bad = done && (meas > unlock_thr); // R6
        events = {missed, nxt_st.counter_reset, 2'b00};
        if (!st_ff.locked) begin
            if (good) begin
                if (st_ff.good_count == need - 8'h01) begin // R5
                    nxt_st.locked = 1'b1;
                    nxt_st.good_count = 8'h00;
                    events[IRQ_LOCKED] = 1'b1;
                end else begin
                    nxt_st.good_count = st_ff.good_count + 8'h01;
                end
            end else if (done) begin
                nxt_st.good_count = 8'h00; // R5
            end
        end else if (bad) begin
            // Only a single wide cycle unlocks; in-between errors are tolerated
            nxt_st.locked = 1'b0; // R6
            nxt_st.good_count = 8'h00;
            events[IRQ_UNLOCKED] = 1'b1;
        end
        // Feedback divide
        nxt_st.b_bypass = (st_ff.b_count == 13'h0001); // R11
        nxt_st.a_bypass = nxt_st.b_bypass | st_ff.prescaler[FD_BIT]; // R12
        if (nxt_st.b_bypass) begin
            nxt_st.fb_divide = 19'(psc); // R11
        end else if (st_ff.prescaler[FD_BIT]) begin
            nxt_st.fb_divide = prod; // R12
        end else begin
            nxt_st.fb_divide = prod + 19'(st_ff.a_count); // R14
        end
        // Output pin multiplexers
        nxt_st.pins.lock_pin = pin_mux(st_ff.lock_sel[1:0], st_ff.locked); // R4
        nxt_st.pins.status_pin = pin_mux(st_ff.abl[STATUS_SEL_LSB +: 2], st_ff.locked); // R4
        nxt_st.pins.reference_monitor_pin = pin_mux(st_ff.reference_monitor_pin_sel[1:0], st_ff.locked); // R4
        // Bus: read data captured in setup, writes land at the access edge
        if (setup && !APB_REQ.pwrite) begin
            nxt_st.prdata = hit ? rd_val : 32'h0000_0000;
        end
        if (access && APB_REQ.pwrite && hit) begin
            unique case (idx)
                IDX_PRESCALER: nxt_st.prescaler = APB_REQ.pwdata[7:0];
                IDX_ANTIBACKLASH: nxt_st.abl = APB_REQ.pwdata[7:0];
                IDX_LOCK_CFG: nxt_st.lock_cfg = APB_REQ.pwdata[7:0];
                IDX_DELAY_SYNC: nxt_st.delay_sync = APB_REQ.pwdata[7:0]; // R2 R3
                IDX_LOCK_PIN_SEL: nxt_st.lock_sel = APB_REQ.pwdata[7:0];
                IDX_REFERENCE_MONITOR_PIN_SEL: nxt_st.reference_monitor_pin_sel = APB_REQ.pwdata[7:0];
                IDX_A_COUNT: nxt_st.a_count = APB_REQ.pwdata[5:0];
                IDX_B_COUNT: nxt_st.b_count = APB_REQ.pwdata[12:0];
                IDX_DELAY_EN: nxt_st.delay_en = APB_REQ.pwdata[1:0]; // R3
                IDX_IRQ_STATUS: w1c = APB_REQ.pwdata[3:0];
                IDX_IRQ_MASK: nxt_st.irq_mask = APB_REQ.pwdata[3:0];
                default: nxt_st.irq_mask = st_ff.irq_mask;
            endcase
        end
        // New events win over a same-cycle clear
        nxt_st.irq_status = (st_ff.irq_status & ~w1c) | events;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_ff <= ST_RESET; // R2 R15
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign APB_RSP.prdata = st_ff.prdata;
    assign APB_RSP.pready = 1'b1;
    assign APB_RSP.pslverr = access & ~hit;
    assign COUNTER_RESET = st_ff.counter_reset;
    assign DELAY_CFG.ref_en = st_ff.delay_en[0]; // R3
    assign DELAY_CFG.ref_code = st_ff.delay_sync[REF_DLY_LSB +: 3];
    assign DELAY_CFG.fb_en = st_ff.delay_en[1]; // R3
    assign DELAY_CFG.fb_code = st_ff.delay_sync[FB_DLY_LSB +: 3];
    assign FB_DIVIDE = st_ff.fb_divide;
    assign FB_A_BYPASS = st_ff.a_bypass;
    assign FB_B_BYPASS = st_ff.b_bypass;
    assign PINS = st_ff.pins;
    // Level output; software clears status, so no pulse is lost while masked
    assign IRQ = |(st_ff.irq_status & st_ff.irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    sequence sync_event_s;
        sync_fall && sync_en;
    endsequence
    sequence delay_write_s;
        access && APB_REQ.pwrite && (idx == IDX_DELAY_SYNC) && (APB_REQ.paddr[11:10] == 2'b00);
    endsequence
    sequence unlock_cycle_s;
        st_ff.locked && bad;
    endsequence

    AST_SYNC_RESET: assert property (sync_event_s |=> COUNTER_RESET ##1 !COUNTER_RESET) // R1
        else $error("sync event did not give a one-cycle counter reset");
    AST_SYNC_OFF: assert property (!sync_en |=> !COUNTER_RESET) // R2
        else $error("counter reset while sync reset disabled");
    AST_DELAY_CODE: assert property (delay_write_s |=> // R3
        DELAY_CFG.fb_code == $past(APB_REQ.pwdata[5:3])
        && DELAY_CFG.ref_code == $past(APB_REQ.pwdata[2:0]))
        else $error("delay codes do not follow the written value");
    AST_PIN_MUX: assert property ((st_ff.lock_sel[1:0] == 2'b01) |=> // R4
        PINS.lock_pin == $past(st_ff.locked))
        else $error("lock pin does not show the lock flag");
    AST_LOCK_GAIN: assert property ($rose(st_ff.locked) |-> // R5
        $past(good && st_ff.good_count == need - 8'h01))
        else $error("lock rose without the full count of good cycles");
    AST_LOCK_HOLD: assert property ((st_ff.locked && !bad) |=> st_ff.locked) // R6
        else $error("lock dropped without a cycle beyond the unlock window");
    AST_UNLOCK: assert property (unlock_cycle_s |=> // R6
        !st_ff.locked && st_ff.irq_status[IRQ_UNLOCKED] && st_ff.good_count == 8'h00)
        else $error("wide cycle did not drop lock");
    AST_WINDOWS: assert property (unlock_thr > lock_thr) // R7
        else $error("unlock window not wider than lock window");
    AST_WIN_SEL: assert property ((st_ff.lock_cfg[LWIN_BIT] && st_ff.abl[1:0] == 2'b01) |-> // R8
        lock_thr == 8'h0a && unlock_thr == 8'h14)
        else $error("window widths wrong for wide select");
    AST_B_BYPASS: assert property ((st_ff.b_count == 13'h0001) |=> // R11
        FB_B_BYPASS && FB_DIVIDE == 19'($past(psc)))
        else $error("B of one did not give prescaler-only divide");
    AST_FIXED_DIV: assert property ((st_ff.prescaler[FD_BIT] && st_ff.b_count != 13'h0001) // R12
        |=> FB_A_BYPASS && FB_DIVIDE == $past(prod))
        else $error("fixed divide mode still used the A count");
    AST_DUAL_DIV: assert property ((!st_ff.prescaler[FD_BIT] && st_ff.b_count != 13'h0001) // R14
        |=> FB_DIVIDE == $past(prod) + 19'($past(st_ff.a_count)))
        else $error("feedback divide is not P times B plus A");
endmodule
`default_nettype wire

// [test/pcs_tb_top.sv]
// Testbench: register access, sync pulse, divide, delays, interrupts and lock detector
`default_nettype none
module pcs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pcs_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    logic clk = 1'b0;
    logic rst_n;
    pcs_apb_req_type req;
    pcs_apb_rsp_type rsp;
    logic ref_in;
    logic fb_in;
    logic sync_n;
    logic crst;
    pcs_delay_type dly;
    logic [18:0] fbdiv;
    logic a_byp;
    logic b_byp;
    pcs_pins_type pins;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    int mismatches = 0;
    int n_tests = 0;
    int n_rst = 0;
    int cycles = 0;
    int p;
    ////////////////////////////////////////////////////////////////////////////
    pcs_top u_dut (
        .SYS_CLK(clk),
        .RST_N(rst_n),
        .APB_REQ(req),
        .APB_RSP(rsp),
        .REF_PFD_IN(ref_in),
        .FB_PFD_IN(fb_in),
        .SYNC_N(sync_n),
        .COUNTER_RESET(crst),
        .DELAY_CFG(dly),
        .FB_DIVIDE(fbdiv),
        .FB_A_BYPASS(a_byp),
        .FB_B_BYPASS(b_byp),
        .PINS(pins),
        .IRQ(irq)
    );
    always #10 clk = ~clk;
    // Counts every cycle of the pulse, so a stretched pulse shows up as extra
    always @(posedge clk) begin
        if (crst === 1'b1) n_rst++;
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        // No wait limit here; the cycle ceiling ends a hung transfer
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        check(rdat & m, e);
    endtask
    task automatic sync_pulse;
        @(posedge clk);
        sync_n <= 1'b0;
        repeat (10) @(posedge clk);
        sync_n <= 1'b1;
        settle(10);
    endtask
    // One detector cycle: reference edge, then feedback edge sp clocks later
    task automatic pfd(input int sp);
        @(posedge clk);
        ref_in <= 1'b1;
        repeat (sp) @(posedge clk);
        fb_in <= 1'b1;
        repeat (3) @(posedge clk);
        ref_in <= 1'b0;
        fb_in <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Spacings: g inside lock window, m between windows, b beyond unlock window
    task automatic lock_seq(input logic [7:0] abl, input logic [7:0] win,
            input logic [7:0] cnt, input int n, input int g, input int m, input int b);
        wr(IDX_IRQ_STATUS, 8'h0f);
        wr(IDX_ANTIBACKLASH, abl | 8'h08);
        wr(IDX_LOCK_CFG, 8'((win << LWIN_BIT) | (cnt << LCNT_LSB)));
        wr(IDX_LOCK_PIN_SEL, 8'h01);
        wr(IDX_REFERENCE_MONITOR_PIN_SEL, 8'h03);
        for (int i = 0; i < n - 1; i++) pfd(g);
        settle(6);
        rd_chk(IDX_LOCK_STATE, 32'h0000ffff, 32'((n - 1) << 8));
        pfd(g);
        settle(6);
        rd_chk(IDX_LOCK_STATE, 32'h1, 32'h1);
        check({29'h0, pins}, 32'h5);
        pfd(m);
        settle(6);
        rd_chk(IDX_LOCK_STATE, 32'h1, 32'h1);
        pfd(b);
        settle(6);
        rd_chk(IDX_LOCK_STATE, 32'h1, 32'h0);
        check({29'h0, pins}, 32'h3);
        rd_chk(IDX_IRQ_STATUS, 32'h3, 32'h3);
        wr(IDX_IRQ_MASK, 8'h02);
        settle(2);
        check({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_MASK, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        req = '0;
        ref_in = 1'b0;
        fb_in = 1'b0;
        sync_n = 1'b1;
        rst_n = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        settle(1);
        check({27'h0, pins, irq, crst}, 32'h0);
        rd_chk(IDX_LOCK_STATE, 32'h0000ffff, 32'h0);
        rd_chk(IDX_DELAY_SYNC, 32'hffffffff, 32'h0);
        rd_chk(IDX_LOCK_CFG, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, rerr}, 32'h1);
        check(rdat, 32'h0);
        wr(IDX_DELAY_SYNC, 8'h1d);
        wr(IDX_DELAY_EN, 8'h03);
        settle(2);
        check({24'h0, dly}, 32'hdb);
        rd_chk(IDX_DELAY_SYNC, 32'hffffffff, 32'h1d);
        n_rst = 0;
        sync_pulse();
        check(n_rst, 32'h0);
        wr(IDX_DELAY_SYNC, 8'h5d);
        n_rst = 0;
        sync_pulse();
        check(n_rst, 32'h1);
        rd_chk(IDX_IRQ_STATUS, 32'hf, 32'h4);
        wr(IDX_IRQ_MASK, 8'h04);
        settle(2);
        check({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_MASK, 8'h00);
        settle(2);
        check({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_MASK, 8'h04);
        wr(IDX_IRQ_STATUS, 8'h04);
        settle(2);
        check({31'h0, irq}, 32'h0);
        rd_chk(IDX_IRQ_STATUS, 32'hf, 32'h0);
        wr(IDX_IRQ_MASK, 8'h00);
        for (p = 0; p < 5; p++) begin
            wr(IDX_PRESCALER, 8'(p));
            wr(IDX_A_COUNT, 8'h03);
            wr(IDX_B_COUNT, 8'h05);
            settle(2);
            check({11'h0, fbdiv, a_byp, b_byp}, ((2 << p) * 5 + 3) << 2);
            wr(IDX_PRESCALER, 8'(p) | 8'h08);
            settle(2);
            check({11'h0, fbdiv, a_byp, b_byp}, (((2 << p) * 5) << 2) | 2);
            wr(IDX_B_COUNT, 8'h01);
            settle(2);
            check({11'h0, fbdiv, a_byp, b_byp}, ((2 << p) << 2) | 3);
        end
        // Prescaler of one in fixed mode, as used for N of 7 at high input rates
        wr(IDX_PRESCALER, 8'h0d);
        wr(IDX_B_COUNT, 8'h07);
        settle(2);
        check({11'h0, fbdiv, a_byp, b_byp}, 32'h1e);
        lock_seq(8'h01, 8'h1, 8'h0, 5, 2, 15, 25);
        lock_seq(8'h00, 8'h0, 8'h1, 16, 8, 15, 25);
        // Feedback edge far too late: saturated spacing flags a missed cycle
        pfd(300);
        settle(6);
        rd_chk(IDX_IRQ_STATUS, 32'h8, 32'h8);
        finish_test();
    end
endmodule
`default_nettype wire
